// ### verilog/ccr_pkg.sv
// package: offsets, fields, resets and carriers of the can core control registers
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`default_nettype none
package ccr_pkg;
    localparam logic [7:0]  CCR_OFF_BYTE_ORDER = 8'h04;
    localparam logic [7:0]  CCR_OFF_FAST_TIME  = 8'h0c;
    localparam logic [7:0]  CCR_OFF_PIN_TEST   = 8'h10;
    localparam logic [7:0]  CCR_OFF_RAM_WDOG   = 8'h14;
    localparam logic [7:0]  CCR_OFF_CORE_CTRL  = 8'h18;
    localparam logic [31:0] CCR_BYTE_ORDER_WORD = 32'h87654321;
    localparam logic [31:0] CCR_FAST_TIME_RST   = 32'h00000a33;
    localparam logic [31:0] CCR_CORE_CTRL_RST   = 32'h00000001;
    localparam int CCR_B_INIT  = 0;
    localparam int CCR_B_UNLK  = 1;
    localparam int CCR_B_RESTR = 2;
    localparam int CCR_B_HACK  = 3;
    localparam int CCR_B_HREQ  = 4;
    localparam int CCR_B_LSTN  = 5;
    localparam int CCR_B_TEST  = 7;
    localparam int CCR_B_FILT  = 13;
    localparam int CCR_B_PAUSE = 14;
    localparam int CCR_B_DCOMP = 23;
    localparam logic [31:0] CCR_CORE_WMASK = 32'h0000fff7;
    localparam logic [31:0] CCR_FAST_WMASK = 32'h009f1fff;
    localparam int CCR_B_LOOP = 4;
    localparam logic [1:0] CCR_TX_CORE = 2'h0;
    localparam logic [1:0] CCR_TX_SAMP = 2'h1;
    localparam logic [1:0] CCR_TX_DOM  = 2'h2;
    localparam logic [1:0] CCR_TX_REC  = 2'h3;
    localparam logic [1:0] CCR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;
    // core-facing status, from the protocol engine on aclk
    typedef struct packed {
        logic       started_number_valid;
        logic [4:0] started_buffer_number;
        logic       prepared_number_valid;
        logic [4:0] prepared_buffer_number;
        logic       xfers_idle;
        logic       tx_core;
        logic       sample_point;
    } ccr_core_s;
    // timing fields presented to the bit timing logic, counts plus one, bit quanta plus three
    typedef struct packed {
        logic [5:0] quantum_clocks;
        logic [5:0] seg_before;
        logic [4:0] seg_after;
        logic [4:0] jump_width;
        logic [6:0] bit_quanta;
        logic       tx_delay_comp_enable;
    } ccr_timing_s;
endpackage
`default_nettype wire

// ### verilog/ccr_regs.sv
// can core control register bank with axi4-lite slave and ram watchdog
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
module ccr_regs (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_awaddr,
    input  wire logic                 s_awvalid,
    output logic                      s_awready,
    input  wire logic [31:0]          s_wdata,
    input  wire logic [3:0]           s_wstrb,
    input  wire logic                 s_wvalid,
    output logic                      s_wready,
    output logic [1:0]                s_bresp,
    output logic                      s_bvalid,
    input  wire logic                 s_bready,
    input  wire logic [7:0]           s_araddr,
    input  wire logic                 s_arvalid,
    output logic                      s_arready,
    output logic [31:0]               s_rdata,
    output logic [1:0]                s_rresp,
    output logic                      s_rvalid,
    input  wire logic                 s_rready,
    input  wire logic                 can_rx_pin,
    output logic                      can_tx_pin,
    output logic                      loopback_enable,
    input  wire ccr_pkg::ccr_core_s   core_status,
    output ccr_pkg::ccr_timing_s      fast_timing,
    output logic                      transmit_pause_enable,
    output logic                      integration_edge_filter,
    output logic                      bus_listen_only,
    output logic                      restricted_operation,
    output logic                      core_init,
    input  wire logic                 ram_select,
    input  wire logic                 ram_ready,
    output logic                      ram_timeout_flag
);
    import ccr_pkg::*;

    // ---------------------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------------------
    logic [31:0] fast_r;
    logic [31:0] core_r;
    logic [1:0]  tx_sel_r;
    logic        loop_r;
    logic [7:0]  wd_start_r;
    logic [7:0]  wd_count_r;
    logic        wd_run_r;
    logic        wd_flag_r;
    logic        rx_s1_r;
    logic        rx_s2_r;
    logic        tx_pin_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    function automatic logic [31:0] ccr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic ccr_mapped(input logic [7:0] a);
        return (a == CCR_OFF_BYTE_ORDER) || (a == CCR_OFF_FAST_TIME) || (a == CCR_OFF_PIN_TEST) ||
               (a == CCR_OFF_RAM_WDOG) || (a == CCR_OFF_CORE_CTRL);
    endfunction

    // ---------------------------------------------------------------------------
    // write channel: address and data may arrive in either order
    // ---------------------------------------------------------------------------
    wire         do_write   = aw_held_r && w_held_r && !bvalid_r;
    wire [7:0]   wr_addr    = {aw_addr_r[7:2], 2'b00};
    wire         unlocked   = core_r[CCR_B_UNLK] && core_r[CCR_B_INIT];
    wire         wr_fast    = do_write && (wr_addr == CCR_OFF_FAST_TIME) && unlocked;
    wire         wr_test    = do_write && (wr_addr == CCR_OFF_PIN_TEST) && core_r[CCR_B_TEST];
    wire         wr_wdog    = do_write && (wr_addr == CCR_OFF_RAM_WDOG) && unlocked;
    wire         wr_core    = do_write && (wr_addr == CCR_OFF_CORE_CTRL);
    wire [31:0]  core_wv    = ccr_merge(core_r, w_data_r, w_strb_r);
    wire [31:0]  test_wv    = ccr_merge({25'h0, tx_sel_r, loop_r, 4'h0}, w_data_r, w_strb_r);
    wire [31:0]  wdog_wv    = ccr_merge({24'h0, wd_start_r}, w_data_r, w_strb_r);

    assign s_awready = !aw_held_r;
    assign s_wready  = !w_held_r;
    assign s_bvalid  = bvalid_r;
    assign s_bresp   = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= CCR_RESP_OKAY;
        end else begin
            if (s_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= ccr_mapped(wr_addr) ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
            end else if (bvalid_r && s_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------------------
    // core control: protected sets, free clears, clock halt sequence
    // ---------------------------------------------------------------------------
    logic [31:0] core_nxt;
    always_comb begin
        core_nxt = core_r;
        if (wr_core) begin
            core_nxt = (core_wv & CCR_CORE_WMASK) | (core_r & ~CCR_CORE_WMASK);
            core_nxt[CCR_B_UNLK] = core_wv[CCR_B_UNLK] & core_nxt[CCR_B_INIT];
            // listen only and restricted may rise only when unlocked, fall anytime
            core_nxt[CCR_B_LSTN]  = core_wv[CCR_B_LSTN] & (core_r[CCR_B_LSTN] | unlocked);
            core_nxt[CCR_B_RESTR] = core_wv[CCR_B_RESTR] & (core_r[CCR_B_RESTR] | unlocked);
        end
        // init first, ack one cycle later; dropping the request drops the ack
        if (core_nxt[CCR_B_HREQ] && core_status.xfers_idle) begin
            core_nxt[CCR_B_INIT] = 1'b1;
        end
        core_nxt[CCR_B_HACK] = core_nxt[CCR_B_HREQ] && core_r[CCR_B_INIT] && core_nxt[CCR_B_INIT] &&
                               core_status.xfers_idle;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_r <= CCR_CORE_CTRL_RST;
            fast_r <= CCR_FAST_TIME_RST;
        end else begin
            core_r <= core_nxt;
            if (wr_fast) begin
                fast_r <= ccr_merge(fast_r, w_data_r, w_strb_r) & CCR_FAST_WMASK;
            end
        end
    end

    // ---------------------------------------------------------------------------
    // fast phase timing outputs, each count plus one, bit quanta plus three
    // ---------------------------------------------------------------------------
    ccr_timing_s timing_nxt;
    ccr_timing_s timing_r;
    assign timing_nxt.quantum_clocks = {1'b0, fast_r[20:16]} + 6'd1;
    assign timing_nxt.seg_before     = {1'b0, fast_r[12:8]} + 6'd1;
    assign timing_nxt.seg_after      = {1'b0, fast_r[7:4]} + 5'd1;
    assign timing_nxt.jump_width     = {1'b0, fast_r[3:0]} + 5'd1;
    // sync segment plus both segments: programmed values plus three
    assign timing_nxt.bit_quanta     = {2'b0, fast_r[12:8]} + {3'b0, fast_r[7:4]} + 7'd3;
    // prescaler range with delay compensation is left to software
    assign timing_nxt.tx_delay_comp_enable = fast_r[CCR_B_DCOMP];
    // no reset of its own: it trails fast_r by one cycle, and fast_r is reset
    always_ff @(posedge aclk) begin
        timing_r <= timing_nxt;
    end
    assign fast_timing = timing_r;

    assign transmit_pause_enable   = core_r[CCR_B_PAUSE];
    assign integration_edge_filter = core_r[CCR_B_FILT];
    assign bus_listen_only         = core_r[CCR_B_LSTN];
    assign restricted_operation    = core_r[CCR_B_RESTR];
    assign core_init               = core_r[CCR_B_INIT];

    // ---------------------------------------------------------------------------
    // pin test: receive sync, transmit source, loopback
    // ---------------------------------------------------------------------------
    logic tx_pin_nxt;
    always_comb begin
        case (tx_sel_r)
            CCR_TX_CORE: tx_pin_nxt = core_status.tx_core; // core updates it at bit end
            CCR_TX_SAMP: tx_pin_nxt = core_status.sample_point;
            CCR_TX_DOM:  tx_pin_nxt = 1'b0;
            CCR_TX_REC:  tx_pin_nxt = 1'b1;
            default:     tx_pin_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            tx_pin_r <= 1'b1;
            tx_sel_r <= CCR_TX_CORE;
            loop_r   <= 1'b0;
        end else begin
            rx_s1_r  <= can_rx_pin;
            rx_s2_r  <= rx_s1_r;
            tx_pin_r <= tx_pin_nxt; // core bit reaches the pin at the first edge after it
            if (!core_r[CCR_B_TEST]) begin
                tx_sel_r <= CCR_TX_CORE;
                loop_r   <= 1'b0;
            end else if (wr_test) begin
                tx_sel_r <= test_wv[6:5];
                loop_r   <= test_wv[CCR_B_LOOP];
            end
        end
    end
    assign can_tx_pin      = tx_pin_r;
    assign loopback_enable = loop_r;

    // ---------------------------------------------------------------------------
    // ram watchdog on the host clock
    // ---------------------------------------------------------------------------
    wire wd_enabled = (wd_start_r != 8'h00);
    wire wd_expire  = wd_run_r && !ram_ready && (wd_count_r == 8'h01);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_start_r <= 8'h00;
            wd_count_r <= 8'h00;
            wd_run_r   <= 1'b0;
            wd_flag_r  <= 1'b0;
        end else begin
            if (wr_wdog) begin
                wd_start_r <= wdog_wv[7:0];
            end
            if (!wd_enabled) begin
                wd_run_r <= 1'b0;
            end else if (ram_ready) begin
                wd_count_r <= wd_start_r;
                wd_run_r   <= 1'b0; // access done; a select still held restarts it next cycle
            end else if (ram_select && !wd_run_r && wd_count_r != 8'h00) begin
                wd_count_r <= wd_start_r;
                wd_run_r   <= 1'b1;
            end else if (ram_select && !wd_run_r && wd_flag_r == 1'b0) begin
                wd_count_r <= wd_start_r;
                wd_run_r   <= 1'b1;
            end else if (wd_run_r) begin
                wd_count_r <= wd_count_r - 8'h01;
                if (wd_expire) begin
                    wd_run_r <= 1'b0;
                end
            end
            // set wins over the clear of the same cycle
            if (wd_expire) begin
                wd_flag_r <= 1'b1;
            end else if (wr_wdog && w_data_r[31]) begin
                wd_flag_r <= 1'b0;
            end
        end
    end
    assign ram_timeout_flag = wd_flag_r;

    // ---------------------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------------------
    wire [7:0]  rd_addr  = {s_araddr[7:2], 2'b00};
    wire [31:0] test_rd  = {10'h0, core_status.started_number_valid, core_status.started_buffer_number,
                            2'h0, core_status.prepared_number_valid, core_status.prepared_buffer_number,
                            rx_s2_r, tx_sel_r, loop_r, 4'h0};
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            CCR_OFF_BYTE_ORDER: rd_mux = CCR_BYTE_ORDER_WORD;
            CCR_OFF_FAST_TIME:  rd_mux = fast_r;
            CCR_OFF_PIN_TEST:   rd_mux = test_rd;
            CCR_OFF_RAM_WDOG:   rd_mux = {wd_flag_r, 15'h0, wd_count_r, wd_start_r};
            CCR_OFF_CORE_CTRL:  rd_mux = core_r;
            default:            rd_mux = 32'h0;
        endcase
    end
    assign s_arready = !rvalid_r;
    assign s_rvalid  = rvalid_r;
    assign s_rdata   = rdata_r;
    assign s_rresp   = rresp_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= CCR_RESP_OKAY;
        end else if (s_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= ccr_mapped(rd_addr) ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
        end else if (rvalid_r && s_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------------
    chk_fast_protect: assert property (@(posedge aclk) disable iff (!aresetn)
        !unlocked |=> $stable(fast_r)) else $error("fast timing changed while locked");
    chk_unlock_init: assert property (@(posedge aclk) disable iff (!aresetn)
        core_r[CCR_B_UNLK] |-> core_r[CCR_B_INIT]) else $error("unlock without init");
    chk_listen_set: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(core_r[CCR_B_LSTN]) |-> $past(unlocked)) else $error("listen only set while locked");
    chk_restr_set: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(core_r[CCR_B_RESTR]) |-> $past(unlocked)) else $error("restricted set while locked");
    chk_halt_order: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(core_r[CCR_B_HACK]) |-> $past(core_r[CCR_B_INIT])) else $error("ack before init");
    chk_test_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        !core_r[CCR_B_TEST] |=> (tx_sel_r == CCR_TX_CORE) && !loop_r) else $error("test not reset");
    chk_tx_forced: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_sel_r == CCR_TX_DOM) |=> !can_tx_pin) else $error("forced dominant not driven");
    chk_rx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |-> ##2 (test_rd[7] == $past(can_rx_pin, 2))) else $error("receive bit stale");
    chk_wd_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_expire |=> wd_flag_r && !wd_run_r && wd_count_r == 8'h00) else $error("watchdog not stopped");
    chk_wd_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !wd_enabled |=> !wd_run_r) else $error("watchdog ran while disabled");
    cov_write_ok: cover property (@(posedge aclk) disable iff (!aresetn) wr_fast);
    cov_halt: cover property (@(posedge aclk) disable iff (!aresetn) $rose(core_r[CCR_B_HACK]));
    cov_wd_fire: cover property (@(posedge aclk) disable iff (!aresetn) wd_expire);
    chk_tx_core: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_sel_r == CCR_TX_CORE) |=> can_tx_pin == $past(core_status.tx_core)) else $error("core bit not on pin");
    chk_wd_start: assert property (@(posedge aclk) disable iff (!aresetn)
        ram_select && !wd_run_r && wd_enabled && !ram_ready && !wd_flag_r |=> wd_run_r &&
        wd_count_r == $past(wd_start_r)) else $error("watchdog not started");
    chk_wd_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        ram_ready && wd_enabled |=> !wd_run_r &&
        wd_count_r == $past(wd_start_r)) else $error("watchdog not reloaded");
    chk_halt_init: assert property (@(posedge aclk) disable iff (!aresetn)
        core_r[CCR_B_HREQ] && core_status.xfers_idle && !wr_core |=>
        core_r[CCR_B_INIT]) else $error("init not set on halt request");
    chk_wdog_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        !unlocked |=> $stable(wd_start_r)) else $error("watchdog start changed while locked");
    cov_listen_set: cover property (@(posedge aclk) disable iff (!aresetn) $rose(core_r[CCR_B_LSTN]));
    cov_tx_dominant: cover property (@(posedge aclk) disable iff (!aresetn) tx_sel_r == CCR_TX_DOM);
endmodule
`default_nettype wire

// ### dv/ccr_can_partner.sv
// far side model: message ram answering after a set latency, and a wired-and can bus
`default_nettype none
module ccr_can_partner (
    input  wire logic       aclk,
    input  wire logic       ram_select,
    input  wire logic [7:0] ram_latency,
    input  wire logic       can_tx_pin,
    input  wire logic       other_nodes_level,
    output logic            ram_ready,
    output logic            can_rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_r;
    // any dominant driver wins, so loop the own transmitter through the bus
    assign can_rx_pin = can_tx_pin & other_nodes_level;
    // latency 8'hff never answers, to let the watchdog run out
    always_ff @(posedge aclk) begin
        if (!ram_select) begin
            wait_r    <= 8'h00;
            ram_ready <= 1'b0;
        end else begin
            wait_r    <= wait_r + 8'h01;
            ram_ready <= (wait_r == ram_latency) && (ram_latency != 8'hff);
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the can core control register bank
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
    logic        s_bvalid, s_arready, s_rvalid, can_rx_pin, can_tx_pin, loopback_enable, transmit_pause_enable;
    logic        integration_edge_filter, bus_listen_only, restricted_operation, core_init, ram_select;
    logic        ram_ready, ram_timeout_flag, bus_lvl, e;
    logic [7:0]  s_awaddr, s_araddr, ram_lat;
    logic [31:0] s_wdata, s_rdata, v;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp;
    ccr_core_s   cs;
    ccr_timing_s fast_timing;
    logic [33:0] qr[$];
    logic [1:0]  qb[$];
    int          err_count, check_count, cyc;
    ccr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .loopback_enable(loopback_enable), .core_status(cs),
        .fast_timing(fast_timing), .transmit_pause_enable(transmit_pause_enable),
        .integration_edge_filter(integration_edge_filter), .bus_listen_only(bus_listen_only),
        .restricted_operation(restricted_operation), .core_init(core_init), .ram_select(ram_select),
        .ram_ready(ram_ready), .ram_timeout_flag(ram_timeout_flag));
    ccr_can_partner u_far (.aclk(aclk), .ram_select(ram_select), .ram_latency(ram_lat), .can_tx_pin(can_tx_pin),
        .other_nodes_level(bus_lvl), .ram_ready(ram_ready), .can_rx_pin(can_rx_pin));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    always #20 aclk = ~aclk;
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // a hang ends the run well past the few hundred cycles the tests need
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("ERROR %0t run did not finish", $time);
            summarize();
        end
    end
    // answers are judged half a cycle ahead, on the falling edge, where both handshake ends are settled
    always @(negedge aclk) begin
        if (s_rvalid && s_rready) chk({s_rresp, s_rdata}, qr.pop_front());
        if (s_bvalid && s_bready) chk(s_bresp, qb.pop_front());
    end
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CCR_RESP_OKAY);
        logic ta, tw, tb;
        qb.push_back(r);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            tb = s_bvalid;
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
        end while (!tb);
        s_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CCR_RESP_OKAY);
        logic ta, tr;
        qr.push_back({r, d});
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_arvalid && s_arready;
            tr = s_rvalid;
            @(posedge aclk);
            if (ta) s_arvalid <= 1'b0;
        end while (!tr);
        s_rready <= 1'b0;
    endtask
    function automatic logic [31:0] tst(input logic rx, input logic [1:0] tx, input logic lb);
        return {10'h0, cs.started_number_valid, cs.started_buffer_number, 2'h0, cs.prepared_number_valid,
                cs.prepared_buffer_number, rx, tx, lb, 4'h0};
    endfunction
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ram_select} = '0;
        {s_awaddr, s_araddr, s_wdata, err_count, check_count, cyc} = '0;
        s_wstrb = 4'hf;
        cs = 15'h0002;
        bus_lvl = 1'b1;
        ram_lat = 8'hff;
        void'($urandom(32'h681a));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CCR_OFF_BYTE_ORDER, CCR_BYTE_ORDER_WORD);
        rd(CCR_OFF_FAST_TIME, CCR_FAST_TIME_RST);
        rd(CCR_OFF_CORE_CTRL, CCR_CORE_CTRL_RST);
        rd(CCR_OFF_PIN_TEST, tst(1'b1, 2'h0, 1'b0));
        rd(CCR_OFF_RAM_WDOG, 32'h0);
        wr(CCR_OFF_BYTE_ORDER, 32'h0);
        rd(CCR_OFF_BYTE_ORDER, CCR_BYTE_ORDER_WORD);
        wr(CCR_OFF_FAST_TIME, 32'h0);
        rd(CCR_OFF_FAST_TIME, CCR_FAST_TIME_RST);
        wr(CCR_OFF_CORE_CTRL, 32'h3);
        rd(CCR_OFF_CORE_CTRL, 32'h3);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h10 : (i == 1) ? 32'h001f1fff : ($urandom() & CCR_FAST_WMASK);
            if (v[23]) v[20:16] = {4'h0, v[16]};
            if (v[7:4] == 4'h0) v[4] = 1'b1;
            wr(CCR_OFF_FAST_TIME, v);
            rd(CCR_OFF_FAST_TIME, v);
            chk(fast_timing, {v[20:16] + 6'd1, v[12:8] + 6'd1, v[7:4] + 5'd1, v[3:0] + 5'd1,
                v[12:8] + v[7:4] + 7'd3, v[23]});
        end
        wr(CCR_OFF_CORE_CTRL, 32'h2);
        rd(CCR_OFF_CORE_CTRL, 32'h0);
        wr(CCR_OFF_FAST_TIME, 32'h0);
        rd(CCR_OFF_FAST_TIME, v);
        wr(CCR_OFF_CORE_CTRL, 32'h6024);
        rd(CCR_OFF_CORE_CTRL, 32'h6000);
        settle(0);
        chk({transmit_pause_enable, integration_edge_filter, bus_listen_only, restricted_operation}, 4'hc);
        wr(CCR_OFF_CORE_CTRL, 32'h3);
        wr(CCR_OFF_CORE_CTRL, 32'h27);
        rd(CCR_OFF_CORE_CTRL, 32'h27);
        settle(0);
        chk({bus_listen_only, restricted_operation, core_init}, 3'h7);
        wr(CCR_OFF_CORE_CTRL, 32'h1);
        rd(CCR_OFF_CORE_CTRL, 32'h1);
        wr(CCR_OFF_PIN_TEST, 32'h70);
        rd(CCR_OFF_PIN_TEST, tst(1'b1, 2'h0, 1'b0));
        cs <= {1'b1, 5'($urandom()), 1'b1, 5'($urandom()), 3'b010};
        wr(CCR_OFF_CORE_CTRL, 32'h81);
        for (int k = 0; k < 4; k++) begin
            wr(CCR_OFF_PIN_TEST, {25'h0, k[1:0], 5'h10});
            bus_lvl <= (k != 3);
            e = (k == 0) ? cs.tx_core : (k == 1) ? cs.sample_point : k[0];
            settle(4);
            chk({loopback_enable, can_tx_pin}, {1'b1, e});
            rd(CCR_OFF_PIN_TEST, tst(e & bus_lvl, k[1:0], 1'b1));
        end
        wr(CCR_OFF_CORE_CTRL, 32'h1);
        bus_lvl <= 1'b1;
        settle(4);
        chk({loopback_enable, can_tx_pin}, 2'b01);
        rd(CCR_OFF_PIN_TEST, tst(1'b1, 2'h0, 1'b0));
        ram_select <= 1'b1;
        settle(20);
        chk(ram_timeout_flag, 1'b0);
        wr(CCR_OFF_CORE_CTRL, 32'h3);
        ram_select <= 1'b0;
        wr(CCR_OFF_RAM_WDOG, 32'h10);
        rd(CCR_OFF_RAM_WDOG, 32'h10);
        ram_lat <= 8'h0a;
        ram_select <= 1'b1;
        repeat (40) begin
            @(negedge aclk);
            if (ram_ready) break;
        end
        @(posedge aclk);
        ram_select <= 1'b0;
        settle(10);
        chk(ram_timeout_flag, 1'b0);
        @(posedge aclk);
        ram_lat <= 8'hff;
        ram_select <= 1'b1;
        settle(14);
        chk(ram_timeout_flag, 1'b0);
        settle(6);
        chk(ram_timeout_flag, 1'b1);
        rd(CCR_OFF_RAM_WDOG, 32'h80000010);
        ram_select <= 1'b0;
        wr(CCR_OFF_RAM_WDOG, 32'h80000010);
        rd(CCR_OFF_RAM_WDOG, 32'h10);
        wr(CCR_OFF_CORE_CTRL, 32'h0);
        rd(CCR_OFF_CORE_CTRL, 32'h0);
        cs.xfers_idle <= 1'b0;
        wr(CCR_OFF_CORE_CTRL, 32'h10);
        rd(CCR_OFF_CORE_CTRL, 32'h10);
        cs.xfers_idle <= 1'b1;
        settle(3);
        chk(core_init, 1'b1);
        rd(CCR_OFF_CORE_CTRL, 32'h19);
        wr(CCR_OFF_CORE_CTRL, 32'h1);
        rd(CCR_OFF_CORE_CTRL, 32'h1);
        rd(8'h08, 32'h0, CCR_RESP_SLVERR);
        wr(8'h20, 32'h5, CCR_RESP_SLVERR);
        settle(4);
        chk(qr.size() + qb.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
